// ### logic/spm_pkg.sv
package spm_pkg;
    // ----------------------------------------
    // Slave-side internal I/O addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_DATA_0 = 8'h20;
    localparam logic [7:0] ADDR_DATA_1 = 8'h21;
    localparam logic [7:0] ADDR_DATA_2 = 8'h22;
    localparam logic [7:0] ADDR_FLAGS = 8'h23;
    localparam logic [7:0] ADDR_CTRL = 8'h24;
    // ----------------------------------------
    // Master-side register select codes
    // ----------------------------------------
    localparam logic [1:0] SEL_DATA_0 = 2'h0;
    localparam logic [1:0] SEL_DATA_2 = 2'h2;
    localparam logic [1:0] SEL_FLAGS = 2'h3;
    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTRL_IGNORE_BIT = 7;
    localparam int CTRL_PIN_HI_BIT = 6;
    localparam int CTRL_PIN_LO_BIT = 5;
    localparam int CTRL_PORT_EN_BIT = 3;
    localparam int CTRL_PORT_DIR_BIT = 2;
    localparam logic [1:0] PRIO_OFF = 2'h0;
    localparam logic [1:0] BOOT_COLD = 2'h1;
    localparam logic [1:0] BOOT_RUN = 2'h0;
    // ----------------------------------------
    // Full-flag register fields
    // ----------------------------------------
    localparam int FLAG_SLAVE_IRQ_BIT = 7;
    localparam int FLAG_IN_BASE = 4;
    localparam int FLAG_ATTN_BIT = 3;
    localparam int FLAG_OUT_BASE = 0;
    localparam int NUM_DATA = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage : spm_pkg

// ### logic/spm_link_if.sv
`timescale 1ns/1ps
// Parallel strobe port between master and slave; data pins as value and enable each side, plus resolved lines
interface spm_link_if;
    logic port_select_n;
    logic port_read_n;
    logic port_write_n;
    logic reg_select_bit0;
    logic reg_select_bit1;
    logic [7:0] master_data_o;
    logic master_data_oe_n;
    logic [7:0] slave_data_o;
    logic slave_data_oe_n;
    logic attention_n;
    logic boot_mode_pin_low;
    logic boot_mode_pin_high;
    // Resolved bus level: whoever enables wins, slave if both enable, pull-up otherwise
    logic [7:0] port_data_lines;
    assign port_data_lines = !slave_data_oe_n ? slave_data_o :
                             (!master_data_oe_n ? master_data_o : 8'hff);
    modport slave_end (
        input port_select_n, port_read_n, port_write_n,
        input reg_select_bit0, reg_select_bit1,
        input port_data_lines, boot_mode_pin_low, boot_mode_pin_high,
        output slave_data_o, slave_data_oe_n, attention_n
    );
    modport master_end (
        output port_select_n, port_read_n, port_write_n,
        output reg_select_bit0, reg_select_bit1,
        output master_data_o, master_data_oe_n, boot_mode_pin_low, boot_mode_pin_high,
        input port_data_lines, attention_n
    );
endinterface : spm_link_if

// ### logic/spm_slave_end.sv
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Each location holds two one-way byte registers.
// RULE_02: Slave sees data 20h-22h, flags 23h, control 24h.
// RULE_03: Master selects data 0-2 or flags; no control.
// RULE_04: Avoid reading while the other side writes.
// RULE_05: Register bits change once, never glitch back.
// RULE_06: Pollers accept two equal reads or one bit.
// RULE_07: Control bit 7 low obeys boot pins.
// RULE_08: Boot pins 01 at reset end start cold boot.
// RULE_09: Boot pins 00 end cold boot, run at zero.
// RULE_10: Control bits 6,5 read boot pin levels.
// RULE_11: Bits 3:2 select mailbox, input or output port.
// RULE_12: Cold boot forces control bit 3 high.
// RULE_13: Bits 1:0 interrupt priority; 00 disables.
// RULE_14: Full flags set by writer, cleared by reader.
// RULE_15: Bit 7 slave interrupt, bit 3 attention flag.
// RULE_16: Drive data only while select and read low.
// RULE_17: Write captured on first rising strobe or select.
// RULE_18: Attention low on slave data 0 write, high on master flag write.
// RULE_19: Either side reads flags; write clears own interrupt.
// RULE_20: Synchronise master strobes, one-cycle events per edge.
// RULE_21: Reset clears flags, attention high, port follows pins.
module spm_slave_end
#(
    parameter int SYNC_STAGES = 2,
    parameter int BUF_DEPTH = 2
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    spm_link_if.slave_end link,
    // Local processor internal I/O
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    // Inbound data-0 stream (cold-boot command bytes), stallable
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic [7:0] cmd_data_o,
    output logic cmd_full_o,
    output logic irq_o,
    output logic [1:0] irq_prio_o,
    output logic cold_boot_o,
    output logic start_at_zero_o,
    output logic port_a_out_o
);
    import spm_pkg::*;
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int NS = 15;
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] sync1_q, sync2_q, sync3_q;
    assign pin_raw = {link.port_data_lines, link.boot_mode_pin_high, link.boot_mode_pin_low,
                      link.reg_select_bit1, link.reg_select_bit0,
                      link.port_write_n, link.port_read_n, link.port_select_n};
    // Two flops per pin, data lines too; third stage only feeds edge detect [RULE_20]
    always_ff @(posedge ref_clk_i)
    begin
        sync1_q <= pin_raw;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end
    logic cs_n, rd_n, wr_n, cs_n_p, rd_n_p, wr_n_p;
    logic [1:0] sel, boot_pins;
    logic [7:0] data_s;
    assign {data_s, boot_pins, sel, wr_n, rd_n, cs_n} = sync2_q;
    assign {wr_n_p, rd_n_p, cs_n_p} = sync3_q[2:0];
    // ----------------------------------------
    // Master access events
    // ----------------------------------------
    logic port_en_q, m_active_p, m_wr_ev, m_rd_ev;
    assign m_active_p = !cs_n_p && !wr_n_p;
    // Write ends on first strobe or select rise; disabled port ignores it [RULE_11] [RULE_17]
    assign m_wr_ev = port_en_q && m_active_p && (wr_n || cs_n);
    // Read counted at end so the byte stays stable through the cycle [RULE_20]
    assign m_rd_ev = port_en_q && !cs_n_p && !rd_n_p && (rd_n || cs_n);
    // Synced byte copied while synced strobe is low; bus floats once strobe rises
    logic [7:0] wr_latch_q;
    always_ff @(posedge ref_clk_i)
    begin
        if (!cs_n && !wr_n)
            wr_latch_q <= data_s;
    end
    // ----------------------------------------
    // Data registers, two per location
    // ----------------------------------------
    logic [7:0] to_slave_q [NUM_DATA], to_master_q [NUM_DATA];
    logic [NUM_DATA-1:0] in_full_q, out_full_q;
    logic slave_irq_q, attn_q;
    logic s_wr, s_rd;
    assign s_wr = io_wr_i;
    assign s_rd = io_rd_i;
    genvar g;
    for (g = 0; g < NUM_DATA; g++)
    begin : g_data
        logic [7:0] a;
        assign a = ADDR_DATA_0 + 8'(g);
        // Separate byte per direction [RULE_01] [RULE_05]
        always_ff @(posedge ref_clk_i)
        begin
            if (reset_i)
                to_slave_q[g] <= RESET_BYTE;
            else if (m_wr_ev && sel == 2'(g))
                to_slave_q[g] <= wr_latch_q;
        end
        always_ff @(posedge ref_clk_i)
        begin
            if (reset_i)
                to_master_q[g] <= RESET_BYTE;
            else if (s_wr && io_addr_i == a)
                to_master_q[g] <= io_wdata_i;
        end
        // Set beats clear in the same cycle [RULE_14]
        always_ff @(posedge ref_clk_i)
        begin
            if (reset_i)
                in_full_q[g] <= 1'b0;
            else if (m_wr_ev && sel == 2'(g))
                in_full_q[g] <= 1'b1;
            else if ((s_rd && io_addr_i == a) || (g == 0 && cmd_valid_o && cmd_ready_i))
                in_full_q[g] <= 1'b0;
        end
        always_ff @(posedge ref_clk_i)
        begin
            if (reset_i)
                out_full_q[g] <= 1'b0;
            else if (s_wr && io_addr_i == a)
                out_full_q[g] <= 1'b1;
            else if (m_rd_ev && sel == 2'(g))
                out_full_q[g] <= 1'b0;
        end
    end
    // ----------------------------------------
    // Interrupt and attention flip-flops
    // ----------------------------------------
    // Master data-0 write sets, slave flag write clears [RULE_15] [RULE_19]
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            slave_irq_q <= 1'b0;
        else if (m_wr_ev && sel == SEL_DATA_0)
            slave_irq_q <= 1'b1;
        else if (s_wr && io_addr_i == ADDR_FLAGS)
            slave_irq_q <= 1'b0;
    end
    // Slave data-0 write sets, master flag write clears [RULE_15] [RULE_18] [RULE_19]
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            attn_q <= 1'b0;
        else if (s_wr && io_addr_i == ADDR_DATA_0)
            attn_q <= 1'b1;
        else if (m_wr_ev && sel == SEL_FLAGS)
            attn_q <= 1'b0;
    end
    assign link.attention_n = !attn_q; // [RULE_18] [RULE_21]
    logic [7:0] flags;
    assign flags = {slave_irq_q, in_full_q, attn_q, out_full_q};
    // ----------------------------------------
    // Control register
    // ----------------------------------------
    logic ignore_pins_q, port_dir_q, boot_q, boot_seen_q;
    logic [1:0] prio_q;
    // Software fields; reset defers port function to the boot pins [RULE_21]
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            ignore_pins_q <= 1'b0;
            port_en_q <= 1'b0;
            port_dir_q <= 1'b0;
            prio_q <= PRIO_OFF;
        end
        else if (s_wr && io_addr_i == ADDR_CTRL)
        begin
            ignore_pins_q <= io_wdata_i[CTRL_IGNORE_BIT]; // [RULE_07]
            port_en_q <= io_wdata_i[CTRL_PORT_EN_BIT]; // [RULE_11]
            port_dir_q <= io_wdata_i[CTRL_PORT_DIR_BIT];
            prio_q <= io_wdata_i[1:0]; // [RULE_13]
        end
        else if (boot_q)
            port_en_q <= 1'b1; // [RULE_12]
    end
    // Pins checked at first cycle after reset, then cold boot until 00 [RULE_08] [RULE_09]
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            boot_q <= 1'b0;
            boot_seen_q <= 1'b0;
            start_at_zero_o <= 1'b0;
        end
        else
        begin
            boot_seen_q <= 1'b1;
            start_at_zero_o <= 1'b0;
            if (!boot_seen_q && !ignore_pins_q && boot_pins == BOOT_COLD)
                boot_q <= 1'b1;
            else if (boot_q && !ignore_pins_q && boot_pins == BOOT_RUN)
            begin
                boot_q <= 1'b0;
                start_at_zero_o <= 1'b1;
            end
        end
    end
    assign cold_boot_o = boot_q;
    assign port_a_out_o = !port_en_q && port_dir_q; // [RULE_11]
    assign irq_prio_o = prio_q;
    assign irq_o = slave_irq_q && prio_q != PRIO_OFF; // [RULE_13]
    // ----------------------------------------
    // Inbound data-0 command buffer
    // ----------------------------------------
    logic [7:0] buf_q [BUF_DEPTH];
    logic [$clog2(BUF_DEPTH+1)-1:0] cnt_q;
    logic [$clog2(BUF_DEPTH)-1:0] rp_q, wp_q;
    logic push, pop;
    // Fed only during cold boot; a full buffer holds off by leaving flag set
    assign push = boot_q && m_wr_ev && sel == SEL_DATA_0 && cnt_q != BUF_DEPTH[$bits(cnt_q)-1:0];
    assign pop = cmd_valid_o && cmd_ready_i;
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            cnt_q <= '0;
            rp_q <= '0;
            wp_q <= '0;
        end
        else
        begin
            if (push)
            begin
                buf_q[wp_q] <= wr_latch_q;
                wp_q <= wp_q + 1'b1;
            end
            if (pop)
                rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + {{($bits(cnt_q)-1){1'b0}}, push}
                           - {{($bits(cnt_q)-1){1'b0}}, pop};
        end
    end
    assign cmd_valid_o = cnt_q != '0;
    assign cmd_data_o = buf_q[rp_q];
    assign cmd_full_o = cnt_q == BUF_DEPTH[$bits(cnt_q)-1:0];
    // ----------------------------------------
    // Read paths
    // ----------------------------------------
    logic [7:0] ctrl_rd;
    assign ctrl_rd = {1'b0, boot_pins[1], boot_pins[0], 5'h00}; // [RULE_10]
    // Slave view at internal addresses [RULE_02]
    always_comb
    begin
        io_rdata_o = 8'h00;
        case (io_addr_i)
            ADDR_DATA_0, ADDR_DATA_1, ADDR_DATA_2:
                io_rdata_o = to_slave_q[2'(io_addr_i - ADDR_DATA_0)];
            ADDR_FLAGS: io_rdata_o = flags;
            ADDR_CTRL: io_rdata_o = ctrl_rd;
            default: io_rdata_o = 8'h00;
        endcase
    end
    // Master view; control unreachable, data held in flops [RULE_03] [RULE_19]
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            link.slave_data_o <= RESET_BYTE;
        else
            link.slave_data_o <= (sel == SEL_FLAGS) ? flags : to_master_q[sel];
    end
    // Drive only with select and read low, and port enabled [RULE_16]
    assign link.slave_data_oe_n = !(port_en_q && !cs_n && !rd_n);
endmodule : spm_slave_end

// ### logic/spm_master_end.sv
`timescale 1ns/1ps
module spm_master_end
    import spm_pkg::*;
#(
    parameter int STROBE_CYCLES = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    spm_link_if.master_end link,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic req_write_i,
    input wire logic [1:0] req_sel_i,
    input wire logic [7:0] req_wdata_i,
    output logic rsp_valid_o,
    output logic [7:0] rsp_rdata_o,
    input wire logic [1:0] boot_mode_i,
    output logic attention_o
);
    import spm_pkg::*;
    typedef enum logic [1:0] {SPM_IDLE, SPM_STROBE, SPM_GAP} spm_state_e;
    spm_state_e state_q;
    logic [7:0] cnt_q;
    logic wr_q;
    logic [1:0] sel_q;
    logic [7:0] wdata_q;
    logic [1:0] at_q;
    // ----------------------------------------
    // Strobe sequencer
    // ----------------------------------------
    // Strobe and recovery both held long to cover slave sync latency
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_q <= SPM_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            sel_q <= SEL_DATA_0;
            wdata_q <= RESET_BYTE;
            rsp_valid_o <= 1'b0;
            rsp_rdata_o <= RESET_BYTE;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            case (state_q)
                SPM_IDLE:
                    if (req_valid_i)
                    begin
                        wr_q <= req_write_i;
                        sel_q <= req_sel_i; // [RULE_03]
                        wdata_q <= req_wdata_i;
                        cnt_q <= 8'(STROBE_CYCLES);
                        state_q <= SPM_STROBE;
                    end
                SPM_STROBE:
                    if (cnt_q == 8'h00)
                    begin
                        if (!wr_q)
                        begin
                            rsp_rdata_o <= link.port_data_lines;
                            rsp_valid_o <= 1'b1;
                        end
                        cnt_q <= 8'(STROBE_CYCLES);
                        state_q <= SPM_GAP;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                SPM_GAP:
                    if (cnt_q == 8'h00)
                        state_q <= SPM_IDLE;
                    else
                        cnt_q <= cnt_q - 8'h01;
                default: state_q <= SPM_IDLE;
            endcase
        end
    end
    assign req_ready_o = state_q == SPM_IDLE;
    assign link.port_select_n = state_q != SPM_STROBE;
    // Write strobe rises with select; slave takes whichever first [RULE_17]
    assign link.port_write_n = !(state_q == SPM_STROBE && wr_q);
    assign link.port_read_n = !(state_q == SPM_STROBE && !wr_q);
    assign link.reg_select_bit0 = sel_q[0];
    assign link.reg_select_bit1 = sel_q[1];
    assign link.master_data_o = wdata_q;
    assign link.master_data_oe_n = !(state_q == SPM_STROBE && wr_q);
    // Boot pins changed to 00 to end cold boot [RULE_09]
    assign link.boot_mode_pin_low = boot_mode_i[0];
    assign link.boot_mode_pin_high = boot_mode_i[1];
    // Attention pin synchronised; output high means slave wrote data 0
    always_ff @(posedge ref_clk_i)
    begin
        at_q <= {at_q[0], !link.attention_n};
    end
    assign attention_o = at_q[1];
endmodule : spm_master_end

// ### dv/spm_props.sv
`timescale 1ns/1ps
// --------
// Link checker
// --------
module spm_props (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic port_select_n,
    input wire logic port_read_n,
    input wire logic port_write_n,
    input wire logic reg_select_bit0,
    input wire logic reg_select_bit1,
    input wire logic [7:0] master_data_o,
    input wire logic master_data_oe_n,
    input wire logic slave_data_oe_n,
    input wire logic attention_n
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Master write to the flag register, ending on the strobe release
    sequence flag_write;
        !port_select_n && !port_write_n && reg_select_bit1 && reg_select_bit0 ##1 port_write_n;
    endsequence
    sequence read_end;
        $rose(port_read_n);
    endsequence
    a_oe_read_end: assert property (read_end |-> ##[1:4] slave_data_oe_n)
        else $error("slave drives after read strobe");
    a_idle_no_drive: assert property (port_read_n [*6] |-> slave_data_oe_n)
        else $error("slave drives without read strobe");
    a_desel_no_drive: assert property (port_select_n [*6] |-> slave_data_oe_n)
        else $error("slave drives while not selected");
    a_no_contention: assert property (!slave_data_oe_n |-> master_data_oe_n)
        else $error("both ends drive the data lines");
    a_write_has_data: assert property (!port_write_n && !port_select_n |-> !master_data_oe_n)
        else $error("write strobe without data driven");
    a_write_hold: assert property (!port_write_n && !$past(port_write_n)
        |-> $stable({reg_select_bit1, reg_select_bit0, master_data_o}))
        else $error("select or data moved during write");
    a_strobe_width: assert property ($fell(port_write_n) |-> !port_write_n [*3])
        else $error("write strobe too short to synchronise");
    a_no_dual_strobe: assert property (!(!port_read_n && !port_write_n))
        else $error("read and write strobes together");
    a_attn_release: assert property (flag_write |-> ##[1:8] attention_n)
        else $error("attention not released by flag write");
    a_reset_idle: assert property ($past(reset_i) |-> attention_n && slave_data_oe_n)
        else $error("attention or drive active after reset");
endmodule : spm_props

// ### dv/slave_port_mailbox_tb.sv
`timescale 1ns/1ps
module slave_port_mailbox_tb;
    import spm_pkg::*;
    localparam int SC = 4;
    localparam int GAP = 2 * (SC + 1) + 1;
    typedef struct packed {
        logic to_m;
        logic [1:0] idx;
        logic [7:0] val;
        logic [7:0] flags;
    } spm_row_s;
    // Ordinary transfers: direction, index, byte, flags expected while full
    spm_row_s rows [5] = '{'{1'h0, 2'h1, 8'ha5, 8'h20}, '{1'h0, 2'h2, 8'h5a, 8'h40},
        '{1'h1, 2'h1, 8'hc3, 8'h02}, '{1'h1, 2'h2, 8'h6e, 8'h04}, '{1'h1, 2'h0, 8'h3c, 8'h09}};
    spm_row_s r;
    logic ref_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [7:0] io_addr_i = 8'h0, io_wdata_i = 8'h0, req_wdata_i = 8'h0, q, io_rdata_o;
    logic [7:0] cmd_data_o, rsp_rdata_o;
    logic io_wr_i = 1'h0, io_rd_i = 1'h0, cmd_ready_i = 1'h0, req_valid_i = 1'h0;
    logic req_write_i = 1'h0;
    logic [1:0] req_sel_i = 2'h0, boot_mode_i = BOOT_RUN, irq_prio_o;
    logic cmd_valid_o, cmd_full_o, irq_o, cold_boot_o, start_at_zero_o, port_a_out_o;
    logic req_ready_o, rsp_valid_o, attention_o;
    int err_total = 0, total_checks = 0, cyc = 0, n;
    // Clock, 8 ns period
    always #4 ref_clk_i = ~ref_clk_i;
    spm_link_if link ();
    spm_slave_end i_spm_slave_end (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(link),
        .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
        .io_rdata_o(io_rdata_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
        .cmd_data_o(cmd_data_o), .cmd_full_o(cmd_full_o), .irq_o(irq_o),
        .irq_prio_o(irq_prio_o), .cold_boot_o(cold_boot_o),
        .start_at_zero_o(start_at_zero_o), .port_a_out_o(port_a_out_o));
    spm_master_end #(.STROBE_CYCLES(SC)) i_spm_master_end (.ref_clk_i(ref_clk_i),
        .reset_i(reset_i), .link(link), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_write_i(req_write_i), .req_sel_i(req_sel_i), .req_wdata_i(req_wdata_i),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .boot_mode_i(boot_mode_i),
        .attention_o(attention_o));
    spm_props i_spm_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .port_select_n(link.port_select_n), .port_read_n(link.port_read_n),
        .port_write_n(link.port_write_n), .reg_select_bit0(link.reg_select_bit0),
        .reg_select_bit1(link.reg_select_bit1), .master_data_o(link.master_data_o),
        .master_data_oe_n(link.master_data_oe_n), .slave_data_oe_n(link.slave_data_oe_n),
        .attention_n(link.attention_n));
    // --------
    // Helpers
    // --------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : results
    // Every helper starts and ends 1 ns after a rising edge
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask : tick
    task automatic sio(input logic wr, input logic [7:0] a, input logic [7:0] d);
        io_addr_i = a;
        io_wdata_i = d;
        io_wr_i = wr;
        io_rd_i = !wr;
        #1;
        q = io_rdata_o;
        tick(1);
        io_wr_i = 1'h0;
        io_rd_i = 1'h0;
        tick(1);
    endtask : sio
    // Request held until taken; the fixed gap keeps master accesses legally spaced
    task automatic mreq(input logic wr, input logic [1:0] s, input logic [7:0] d);
        int k;
        k = 0;
        req_valid_i = 1'h1;
        req_write_i = wr;
        req_sel_i = s;
        req_wdata_i = d;
        while (req_ready_o !== 1'h1 && k < 100)
        begin
            tick(1);
            k++;
        end
        tick(1);
        req_valid_i = 1'h0;
        while (!wr && rsp_valid_o !== 1'h1 && k < 200)
        begin
            tick(1);
            k++;
        end
        chk("master done", 8'(k < 100), 8'h1);
        q = rsp_rdata_o;
        tick(GAP);
    endtask : mreq
    task automatic do_reset(input logic [1:0] pins);
        boot_mode_i = pins;
        reset_i = 1'h1;
        tick(10);
        reset_i = 1'h0;
        tick(2);
    endtask : do_reset
    // Hang guard
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (cyc == 8000)
        begin
            err_total++;
            results();
        end
    end
    // --------
    // Main sequence
    // --------
    initial
    begin
        do_reset(BOOT_RUN);
        chk("attn reset", link.attention_n, 8'h1);
        sio(1'h0, ADDR_FLAGS, 8'h0);
        chk("flags reset", q, 8'h0);
        chk("port reset", port_a_out_o, 8'h0);
        sio(1'h1, ADDR_CTRL, 8'h8c);
        // Sides never read a byte the other side is writing
        foreach (rows[i])
        begin
            r = rows[i];
            if (!r.to_m)
            begin
                mreq(1'h1, r.idx, r.val);
                sio(1'h0, ADDR_FLAGS, 8'h0);
                chk("flags in", q, r.flags);
                sio(1'h0, ADDR_DATA_0 + 8'(r.idx), 8'h0);
                chk("slave read", q, r.val);
            end
            else
            begin
                sio(1'h1, ADDR_DATA_0 + 8'(r.idx), r.val);
                sio(1'h0, ADDR_FLAGS, 8'h0);
                chk("flags out", q, r.flags);
                mreq(1'h0, r.idx, 8'h0);
                chk("master read", q, r.val);
            end
            mreq(1'h0, SEL_FLAGS, 8'h0);
            chk("flags after", q, r.flags & 8'h08);
            $display("row %0d done", i);
        end
        chk("attn pin", link.attention_n, 8'h0);
        chk("attn low", attention_o, 8'h1);
        mreq(1'h1, SEL_FLAGS, 8'h5a);
        chk("attn high", attention_o, 8'h0);
        sio(1'h0, ADDR_FLAGS, 8'h0);
        chk("flags clear", q, 8'h0);
        $display("attention test done");
        // Cold boot with a stalled command consumer
        do_reset(BOOT_COLD);
        chk("cold boot", cold_boot_o, 8'h1);
        sio(1'h0, ADDR_CTRL, 8'h0);
        chk("ctrl pins", q, 8'h20);
        for (int k = 0; k < 3; k++)
            mreq(1'h1, SEL_DATA_0, 8'h10 + 8'(k));
        chk("cmd full", cmd_full_o, 8'h1);
        chk("irq off", irq_o, 8'h0);
        for (int k = 0; k < 2; k++)
        begin
            chk("cmd data", cmd_data_o, 8'h10 + 8'(k));
            cmd_ready_i = 1'h1;
            tick(1);
            cmd_ready_i = 1'h0;
            tick(1);
        end
        cmd_ready_i = 1'h1;
        n = 0;
        while (cmd_valid_o !== 1'h0 && n < 4)
        begin
            tick(1);
            n++;
        end
        chk("cmd empty", cmd_valid_o, 8'h0);
        boot_mode_i = BOOT_RUN;
        n = 0;
        while (start_at_zero_o !== 1'h1 && n < 20)
        begin
            tick(1);
            n++;
        end
        chk("start zero", start_at_zero_o, 8'h1);
        tick(1);
        chk("boot over", cold_boot_o, 8'h0);
        $display("cold boot test done");
        // Every priority code, interrupt raised by data 0 and cleared by flag write
        for (int p = 0; p < 4; p++)
        begin
            sio(1'h1, ADDR_CTRL, {6'h23, p[1:0]});
            mreq(1'h1, SEL_DATA_0, 8'h77);
            chk("prio", irq_prio_o, 8'(p));
            chk("irq", irq_o, 8'(p != 0));
            sio(1'h1, ADDR_FLAGS, 8'hff);
            tick(1);
            chk("irq clear", irq_o, 8'h0);
            sio(1'h0, ADDR_DATA_0, 8'h0);
            chk("data 0", q, 8'h77);
        end
        // Every port function code
        for (int k = 0; k < 4; k++)
        begin
            sio(1'h1, ADDR_CTRL, {4'h8, k[1:0], 2'h0});
            tick(1);
            chk("port dir", port_a_out_o, 8'(k == 1));
        end
        sio(1'h1, ADDR_CTRL, 8'h80);
        mreq(1'h1, 2'h1, 8'h99);
        sio(1'h0, ADDR_FLAGS, 8'h0);
        chk("port off", q, 8'h0);
        $display("control test done");
        results();
    end
endmodule : slave_port_mailbox_tb
